// ==== tsp_top.sv ====
/*
 Temperature signal processing chain: averaging, hold, calibration,
 digital streaming, analog scaling and threshold alarm, with an APB slave.
 Assumes samples arrive from logic on REF_CLK as signed tenths of a degree
 with a one-cycle valid, and that the APB master runs on REF_CLK.
*/
// Local design decisions: the APB interface to the registers and the address map.
`include "tsp_consts.svh"
`default_nettype none
// Operation
// - Normal averaging outputs the mean of samples in the configured window.
// - Hysteresis averaging passes a rise above the hysteresis straight through.
// - Minimum search holds the previous level on a rise for the hold time.
// - Maximum search holds the previous peak on a fall for the hold time.
// - Extended minimum accepts a higher minimum only after exceeding the threshold.
// - With hysteresis the higher minimum must also rise by the hysteresis.
// - Extended maximum accepts a lower peak only after falling below the threshold.
// - With hysteresis the lower peak must also drop by the hysteresis.
// - Five quantities are selectable for digital output.
// - Processed quantity has averaging, hold and calibration applied.
// - Averaged quantity has averaging only; raw bypasses all stages.
// - Stream the configured number of slots, each with its chosen quantity.
// - Output mode enables either the voltage or the current output.
// - Disabled output mode switches every analog output off.
// - Analog value maps temperature linearly between configured level pairs.
// - Loop maintenance drives only simulation values on digital and analog.
// - User calibration applies an offset and a gain to the temperature.
// - Alarm compares a selectable source quantity against the switching temperature.
// - Crossing the switching temperature triggers the alarm and toggles the output.
// - Alarm source off deactivates the alarm output.
// - Advanced alarm settings use both switching temperature and hysteresis.
module tsp_top
   import tsp_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic NRST,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Samples from the measurement front end
   input wire logic SAMPLE_VALID,
   input wire logic [15:0] RAW_TEMP,
   input wire logic [15:0] CONTROLLER_TEMP,
   input wire logic [15:0] HEAD_TEMP,
   // Digital stream
   output tsp_stream_t STREAM,
   // Analog output
   output logic VOLT_EN,
   output logic CURR_EN,
   output logic [15:0] ANALOG_CODE,
   // Open-collector alarm
   output logic ALARM_O,
   output logic ALARM_OE
);

   logic [31:0] cfg [0:`TSP_NCFG-1];
   logic [31:0] rd_mux;
   logic signed [15:0] raw_temp;
   logic signed [15:0] averaged_temp;
   logic signed [15:0] held;
   logic signed [15:0] processed_temp;
   logic signed [19:0] acc;
   logic [4:0] cnt;
   logic [15:0] timer;
   logic armed;
   logic v1, v2, v3;
   logic alarm_state;
   logic [2:0] slot_i;
   logic streaming;
   logic raw_upd;

   // APB decode; answer comes one cycle into the access phase
   wire [3:0] widx = PADDR[5:2];
   wire aligned = (PADDR[1:0] == 2'h0) && (PADDR[7:6] == 2'h0);
   wire mapped = aligned && (widx <= `TSP_R_STAT);
   wire access = PSEL & PENABLE & ~PREADY;
   wire wr_en = PSEL & PENABLE & PREADY & PWRITE & mapped;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (mapped && widx == `TSP_R_STAT)
         rd_mux = {15'h0000, alarm_state, processed_temp};
      else if (mapped)
         rd_mux = cfg[widx];
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         PREADY <= 1'b0;
         PRDATA <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= access;
         PRDATA <= access ? rd_mux : 32'h0000_0000;
         PSLVERR <= access & ~mapped;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `TSP_NCFG; gi++) begin : g_cfg
         localparam logic [31:0] RV = (gi == `TSP_R_CTRL) ? `TSP_RST_CTRL :
            (gi == `TSP_R_CAL) ? `TSP_RST_CAL : `TSP_RST_ZERO;
         always_ff @(posedge REF_CLK or negedge NRST) begin
            if (!NRST)
               cfg[gi] <= RV;
            else if (wr_en && widx == 4'(gi))
               cfg[gi] <= PWDATA;
         end
      end
   endgenerate

   // Configuration fields
   wire [31:0] ctrl = cfg[`TSP_R_CTRL];
   wire avg_hys = ctrl[`TSP_F_AVGHYS];
   wire [2:0] len_raw = ctrl[`TSP_F_AVGLEN];
   wire [2:0] len_log = (len_raw > `TSP_AVG_MAXLOG) ? `TSP_AVG_MAXLOG : len_raw;
   wire tsp_hold_t hmode = tsp_hold_t'(ctrl[`TSP_F_HMODE]);
   wire hold_hys = ctrl[`TSP_F_HHYS];
   wire tsp_omode_t omode = tsp_omode_t'(ctrl[`TSP_F_OMODE]);
   wire loop_on = ctrl[`TSP_F_LOOP];
   wire tsp_asrc_t asrc = tsp_asrc_t'(ctrl[`TSP_F_ASRC]);
   wire alarm_nc = ctrl[`TSP_F_ANC];
   wire alarm_adv = ctrl[`TSP_F_AADV];
   wire [2:0] nslot_raw = ctrl[`TSP_F_NSLOT];
   wire [2:0] nslot = (nslot_raw > `TSP_NQTY) ? `TSP_NQTY : nslot_raw;
   wire [31:0] slotsel = cfg[`TSP_R_SLOT];
   wire signed [15:0] avg_hyst = cfg[`TSP_R_AVGH][`TSP_F_LO];
   wire [15:0] tmin_hold = cfg[`TSP_R_HTIM][`TSP_F_LO];
   wire [15:0] tmax_hold = cfg[`TSP_R_HTIM][`TSP_F_HI];
   wire signed [15:0] hthr = cfg[`TSP_R_HTHR][`TSP_F_LO];
   wire signed [15:0] hhys = cfg[`TSP_R_HTHR][`TSP_F_HI];
   wire signed [15:0] cal_off = cfg[`TSP_R_CAL][`TSP_F_LO];
   wire [15:0] cal_gain = cfg[`TSP_R_CAL][`TSP_F_HI];
   wire [15:0] lvl_min = cfg[`TSP_R_ALVL][`TSP_F_LO];
   wire [15:0] lvl_max = cfg[`TSP_R_ALVL][`TSP_F_HI];
   wire signed [15:0] at_min = cfg[`TSP_R_ATMP][`TSP_F_LO];
   wire signed [15:0] at_max = cfg[`TSP_R_ATMP][`TSP_F_HI];
   wire signed [15:0] al_thr = cfg[`TSP_R_ALRM][`TSP_F_LO];
   wire signed [15:0] al_hys_cfg = cfg[`TSP_R_ALRM][`TSP_F_HI];
   wire [15:0] sim_dig = cfg[`TSP_R_SIM][`TSP_F_LO];
   wire [15:0] sim_ana = cfg[`TSP_R_SIM][`TSP_F_HI];

   // Averaging: block mean over 2^len samples
   wire [4:0] len_m1 = 5'((6'h01 << len_log) - 6'h01);
   wire signed [19:0] acc_sum = acc + 20'(raw_temp);
   wire signed [19:0] mean = acc_sum >>> len_log;
   wire signed [16:0] jump_lvl = 17'(averaged_temp) + 17'(avg_hyst);
   wire jump = avg_hys && (17'(raw_temp) > jump_lvl);

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST)
         raw_temp <= 16'h0000;
      else if (SAMPLE_VALID)
         raw_temp <= RAW_TEMP;
   end

   // A pass-through restarts the window so the mean does not drag old values
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         averaged_temp <= 16'h0000;
         acc <= 20'h00000;
         cnt <= 5'h00;
         v1 <= 1'b0;
      end else begin
         v1 <= 1'b0;
         if (raw_upd) begin
            if (jump) begin
               averaged_temp <= raw_temp;
               acc <= 20'h00000;
               cnt <= 5'h00;
            end else if (cnt >= len_m1) begin
               averaged_temp <= mean[15:0];
               acc <= 20'h00000;
               cnt <= 5'h00;
            end else begin
               acc <= acc_sum;
               cnt <= cnt + 5'h01;
            end
            v1 <= 1'b1;
         end
      end
   end

   // One stage per cycle after the sample is latched
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST)
         raw_upd <= 1'b0;
      else
         raw_upd <= SAMPLE_VALID;
   end

   // Hold stage
   wire signed [16:0] h_dn = 17'(held) - 17'(hhys);
   wire signed [16:0] h_up = 17'(held) + 17'(hhys);
   wire xmax_ok = ~hold_hys | (17'(averaged_temp) <= h_dn);
   wire xmin_ok = ~hold_hys | (17'(averaged_temp) >= h_up);

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         held <= 16'h0000;
         timer <= 16'h0000;
         armed <= 1'b0;
         v2 <= 1'b0;
      end else begin
         v2 <= v1;
         if (v1) begin
            unique case (hmode)
               HOLD_MAX: begin
                  if (averaged_temp >= held) begin
                     held <= averaged_temp;
                     timer <= tmax_hold;
                  end else if (timer == 16'h0000)
                     held <= averaged_temp;
                  else
                     timer <= timer - 16'h0001;
               end
               HOLD_MIN: begin
                  if (averaged_temp <= held) begin
                     held <= averaged_temp;
                     timer <= tmin_hold;
                  end else if (timer == 16'h0000)
                     held <= averaged_temp;
                  else
                     timer <= timer - 16'h0001;
               end
               HOLD_XMAX: begin
                  if (averaged_temp >= held)
                     held <= averaged_temp;
                  else if (armed && xmax_ok) begin
                     held <= averaged_temp;
                     armed <= 1'b0;
                  end else if (averaged_temp < hthr)
                     armed <= 1'b1;
               end
               HOLD_XMIN: begin
                  if (averaged_temp <= held)
                     held <= averaged_temp;
                  else if (armed && xmin_ok) begin
                     held <= averaged_temp;
                     armed <= 1'b0;
                  end else if (averaged_temp > hthr)
                     armed <= 1'b1;
               end
               default: begin
                  held <= averaged_temp;
                  armed <= 1'b0;
               end
            endcase
         end
      end
   end

   // Calibration: gain has TSP_GAIN_FRAC fraction bits, result wraps at 16 bits
   wire signed [33:0] cal_prod = 34'(held) * $signed({18'h00000, cal_gain});
   wire signed [33:0] cal_shift = cal_prod >>> `TSP_GAIN_FRAC;
   wire signed [15:0] cal_res = cal_shift[15:0] + cal_off;

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         processed_temp <= 16'h0000;
         v3 <= 1'b0;
      end else begin
         v3 <= v2;
         if (v2)
            processed_temp <= cal_res;
      end
   end

   // Quantity selection shared by stream and alarm
   function automatic logic [15:0] pick(input logic [2:0] q,
         input logic [15:0] p, input logic [15:0] a, input logic [15:0] r,
         input logic [15:0] c, input logic [15:0] h);
      logic [15:0] v;
      v = p;
      unique case (tsp_qty_t'(q))
         Q_AVG: v = a;
         Q_RAW: v = r;
         Q_CTRL: v = c;
         Q_HEAD: v = h;
         default: v = p;
      endcase
      return v;
   endfunction : pick

   // Digital stream, one slot per cycle after each processed sample
   wire [2:0] cur_qty = slotsel[slot_i*`TSP_W_QTY +: `TSP_W_QTY];
   wire [15:0] cur_val = pick(cur_qty, processed_temp, averaged_temp,
      raw_temp, CONTROLLER_TEMP, HEAD_TEMP);
   wire [15:0] cur_data = loop_on ? sim_dig : cur_val;
   wire slot_go = streaming && (slot_i < nslot);

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         STREAM <= '0;
         slot_i <= 3'h0;
         streaming <= 1'b0;
      end else begin
         STREAM.valid <= slot_go;
         STREAM.slot <= slot_i;
         STREAM.qty <= cur_qty;
         STREAM.data <= cur_data;
         if (v3) begin
            streaming <= 1'b1;
            slot_i <= 3'h0;
         end else if (slot_go)
            slot_i <= slot_i + 3'h1;
         else
            streaming <= 1'b0;
      end
   end

   // Analog scaling with clamping at both temperature limits
   wire signed [16:0] t_rel = 17'(processed_temp) - 17'(at_min);
   wire signed [16:0] t_span = 17'(at_max) - 17'(at_min);
   wire signed [17:0] l_span = $signed({2'h0, lvl_max}) - $signed({2'h0, lvl_min});
   wire signed [35:0] a_num = 36'(t_rel) * 36'(l_span);
   wire signed [35:0] a_quo = (t_span > 17'sh00000) ? a_num / 36'(t_span) : 36'h0;
   wire [15:0] a_lin = lvl_min + a_quo[15:0];
   wire [15:0] a_scaled = (t_rel <= 17'sh00000) ? lvl_min :
      (processed_temp >= at_max) ? lvl_max : a_lin;

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         VOLT_EN <= 1'b0;
         CURR_EN <= 1'b0;
         ANALOG_CODE <= 16'h0000;
      end else begin
         VOLT_EN <= (omode == O_VOLT);
         CURR_EN <= (omode == O_CURR);
         if (omode != O_VOLT && omode != O_CURR)
            ANALOG_CODE <= 16'h0000;
         else if (loop_on)
            ANALOG_CODE <= sim_ana;
         else if (v3)
            ANALOG_CODE <= a_scaled;
      end
   end

   // Alarm with hysteresis; hysteresis is only used with advanced settings
   wire [15:0] diff_t = raw_temp - HEAD_TEMP;
   wire [15:0] asrc_val = (asrc == A_DIFF) ? diff_t :
      pick(3'(ctrl[`TSP_F_ASRC] - 3'h1), processed_temp, averaged_temp,
      raw_temp, CONTROLLER_TEMP, HEAD_TEMP);
   wire signed [15:0] al_hys = alarm_adv ? al_hys_cfg : 16'sh0000;
   wire signed [16:0] al_clr = 17'(al_thr) - 17'(al_hys);
   wire alarm_off = (asrc == A_OFF) || (ctrl[`TSP_F_ASRC] > 3'(A_DIFF));

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         alarm_state <= 1'b0;
         ALARM_OE <= 1'b0;
         ALARM_O <= 1'b0;
      end else begin
         if (alarm_off)
            alarm_state <= 1'b0;
         else if (!alarm_state && $signed(asrc_val) > al_thr)
            alarm_state <= 1'b1;
         else if (alarm_state && 17'($signed(asrc_val)) < al_clr)
            alarm_state <= 1'b0;
         ALARM_O <= 1'b0;
         ALARM_OE <= ~alarm_off & (alarm_state ^ alarm_nc);
      end
   end

endmodule : tsp_top
`default_nettype wire

// ==== tsp_consts.svh ====
/*
 Constants of the temperature signal processing block: register word
 offsets, field positions and reset values.
 Assumes it is included once per file by its bare name.
*/
`ifndef TSP_CONSTS_SVH
`define TSP_CONSTS_SVH

// Register byte offsets
`define TSP_A_CTRL 8'h00
`define TSP_A_SLOT 8'h04
`define TSP_A_AVGH 8'h08
`define TSP_A_HTIM 8'h0c
`define TSP_A_HTHR 8'h10
`define TSP_A_CAL 8'h14
`define TSP_A_ALVL 8'h18
`define TSP_A_ATMP 8'h1c
`define TSP_A_ALRM 8'h20
`define TSP_A_SIM 8'h24
`define TSP_A_STAT 8'h28

// Word indices of the same registers
`define TSP_R_CTRL 4'h0
`define TSP_R_SLOT 4'h1
`define TSP_R_AVGH 4'h2
`define TSP_R_HTIM 4'h3
`define TSP_R_HTHR 4'h4
`define TSP_R_CAL 4'h5
`define TSP_R_ALVL 4'h6
`define TSP_R_ATMP 4'h7
`define TSP_R_ALRM 4'h8
`define TSP_R_SIM 4'h9
`define TSP_R_STAT 4'ha
`define TSP_NCFG 10

// Control register fields
`define TSP_F_AVGHYS 0
`define TSP_F_AVGLEN 3:1
`define TSP_F_HMODE 6:4
`define TSP_F_HHYS 7
`define TSP_F_OMODE 9:8
`define TSP_F_LOOP 10
`define TSP_F_ASRC 14:12
`define TSP_F_ANC 15
`define TSP_F_AADV 16
`define TSP_F_NSLOT 19:17

// Low and high halves of paired registers
`define TSP_F_LO 15:0
`define TSP_F_HI 31:16
`define TSP_W_QTY 3

// Reset values: one slot of processed temperature, unity gain
`define TSP_RST_CTRL 32'h0002_0000
`define TSP_RST_CAL 32'h0400_0000
`define TSP_RST_ZERO 32'h0000_0000

// Gain is fixed point with this many fraction bits
`define TSP_GAIN_FRAC 10
`define TSP_AVG_MAXLOG 3'h4
`define TSP_NQTY 3'h5

`endif

// ==== tsp_pkg.sv ====
/*
 Types of the temperature signal processing block.
 Assumes tsp_consts.svh is available on the include path.
*/
`default_nettype none
package tsp_pkg;
   typedef enum logic [2:0] {HOLD_OFF, HOLD_MIN, HOLD_MAX, HOLD_XMIN, HOLD_XMAX} tsp_hold_t;
   typedef enum logic [2:0] {Q_PROC, Q_AVG, Q_RAW, Q_CTRL, Q_HEAD} tsp_qty_t;
   typedef enum logic [2:0] {A_OFF, A_PROC, A_AVG, A_RAW, A_CTRL, A_HEAD, A_DIFF} tsp_asrc_t;
   typedef enum logic [1:0] {O_OFF, O_VOLT, O_CURR} tsp_omode_t;
   typedef struct packed {
      logic valid;
      logic [2:0] slot;
      logic [2:0] qty;
      logic [15:0] data;
   } tsp_stream_t;
endpackage : tsp_pkg
`default_nettype wire

// ==== tsp_top_assertions.sv ====
/*
 Checker bound to tsp_top: APB answer timing, stream framing, analog enables.
 Assumes the single clock REF_CLK and the active-low reset NRST.
*/
`default_nettype none
module tsp_top_assertions
   import tsp_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic NRST,
   // APB
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // Samples and outputs
   input wire logic SAMPLE_VALID,
   input wire tsp_stream_t STREAM,
   input wire logic VOLT_EN,
   input wire logic CURR_EN,
   input wire logic [15:0] ANALOG_CODE,
   input wire logic ALARM_O
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!NRST);
   sequence s_wait;
      PSEL && PENABLE && !PREADY;
   endsequence
   sequence s_slot0;
      STREAM.valid && STREAM.slot == 3'h0;
   endsequence
   a_ready_wait: assert property (s_wait |=> PREADY)
      else $error("ready missing");
   a_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready too long");
   a_ready_idle: assert property (!PSEL |-> !PREADY && PRDATA == 32'h0)
      else $error("answer while idle");
   a_err_addr: assert property (PREADY && (PADDR[1:0] != 2'h0 || PADDR > 8'h28) |-> PSLVERR)
      else $error("bad address accepted");
   a_err_only: assert property (PSLVERR |-> PREADY && (PADDR[1:0] != 2'h0 || PADDR > 8'h28))
      else $error("good address refused");
   a_out_excl: assert property (!(VOLT_EN && CURR_EN))
      else $error("both analog outputs on");
   a_off_code: assert property (!VOLT_EN && !CURR_EN |-> ANALOG_CODE == 16'h0)
      else $error("code while off");
   a_alarm_low: assert property (ALARM_O == 1'b0)
      else $error("alarm pin driven high");
   a_first_slot: assert property (SAMPLE_VALID |-> ##[5:7] s_slot0)
      else $error("no stream after sample");
   a_slot_next: assert property (STREAM.valid && STREAM.slot != 3'h0 |->
      $past(STREAM.valid) && STREAM.slot == $past(STREAM.slot) + 3'h1)
      else $error("slot out of order");
   a_slot_range: assert property (STREAM.valid |-> STREAM.slot <= 3'h4 && STREAM.qty <= 3'h4)
      else $error("slot or quantity out of range");
endmodule : tsp_top_assertions

bind tsp_top tsp_top_assertions chk (.REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL),
   .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .SAMPLE_VALID(SAMPLE_VALID), .STREAM(STREAM), .VOLT_EN(VOLT_EN), .CURR_EN(CURR_EN),
   .ANALOG_CODE(ANALOG_CODE), .ALARM_O(ALARM_O));
`default_nettype wire

// ==== tsp_front_model.sv ====
/*
 Front-end model: one raw sample per call, housekeeping temperatures as levels.
 Assumes the bench clock; the raw line is valid only in the strobe cycle.
*/
`default_nettype none
module tsp_front_model (
   // Clock
   input wire logic clk,
   // Sample side
   output logic sample_valid,
   output logic [15:0] raw_temp,
   output logic [15:0] controller_temp,
   output logic [15:0] head_temp
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sample_valid = 1'b0;
      raw_temp = 16'h0;
      controller_temp = 16'h0;
      head_temp = 16'h0;
   end
   // Inverted value after the strobe so a late capture is caught
   task automatic send(input logic [15:0] v);
      @(posedge clk);
      sample_valid <= 1'b1;
      raw_temp <= v;
      @(posedge clk);
      sample_valid <= 1'b0;
      raw_temp <= ~v;
   endtask : send
   task automatic levels(input logic [15:0] c, input logic [15:0] h);
      @(posedge clk);
      controller_temp <= c;
      head_temp <= h;
   endtask : levels
endmodule : tsp_front_model
`default_nettype wire

// ==== tsp_top_tb.sv ====
/*
 Bench for tsp_top: APB setup, samples, stream, analog and alarm pins
 against a behavioural model. Assumes the front-end model and checker.
*/
`include "tsp_consts.svh"
`default_nettype none
module tsp_top_tb
   import tsp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, nrst, psel, penable, pwrite, pready, pslverr, sv, ven, cen, al_o, al_oe, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] raw, ct, ht, acode;
   tsp_stream_t strm;
   tsp_stream_t got[$];
   int n_fail, n_checks, win[$];
   int hys, lg, hm, om, lp, asrc, nc, adv, nsl, off, gain, ovr, avgh, athr, ah;
   int sim_d, sim_a, m_avg, alm, ctl, hd, hh, p_pr, p_avg, p_r;
   int sq[5] = '{2, 0, 4, 1, 3};
   int hv[5] = '{200, 200, 400, 420, 400};
   tsp_top dut (
      .REF_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .SAMPLE_VALID(sv), .RAW_TEMP(raw), .CONTROLLER_TEMP(ct), .HEAD_TEMP(ht),
      .STREAM(strm), .VOLT_EN(ven), .CURR_EN(cen), .ANALOG_CODE(acode),
      .ALARM_O(al_o), .ALARM_OE(al_oe)
   );
   tsp_front_model fe (
      .clk(clk), .sample_valid(sv), .raw_temp(raw), .controller_temp(ct), .head_temp(ht)
   );
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      if (strm.valid === 1'b1) got.push_back(strm);
   end
   task automatic end_of_test();
      if (n_fail == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic er);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd, e);
      chk({31'h0, e}, 32'h0);
   endtask : wr
   task automatic cfg();
      wr(`TSP_A_CTRL, 32'(hys | lg << 1 | hm << 4 | om << 8 | lp << 10 | asrc << 12
         | nc << 15 | adv << 16 | nsl << 17 | hh << 7));
   endtask : cfg
   // The design watches its alarm source every cycle, old values after a cfg too
   function automatic void alarm_step(input int p, input int a, input int r);
      int src;
      src = asrc == 1 ? p : asrc == 2 ? a : asrc == 3 ? r : asrc == 4 ? ctl
         : asrc == 5 ? hd : r - hd;
      alm = asrc == 0 ? 0 : src > athr ? 1
         : src < athr - (adv != 0 ? ah : 0) ? 0 : alm;
   endfunction : alarm_step
   // Model steps first, then the sample goes out and every result is compared
   task automatic smp(input int r);
      int pr, c, oe;
      int q[5];
      tsp_stream_t x;
      alarm_step(p_pr, p_avg, p_r);
      if (hys != 0 && r > m_avg + avgh) begin
         m_avg = r;
         win.delete();
      end else begin
         win.push_back(r);
      end
      if (win.size() == (1 << lg)) begin
         m_avg = win.sum() >> lg;
         win.delete();
      end
      pr = (ovr >= 0 ? ovr : m_avg) * gain / 1024 + off;
      q = '{pr, m_avg, r, ctl, hd};
      c = pr + 100;
      c = c < 100 ? 100 : c > 1100 ? 1100 : c;
      alarm_step(pr, m_avg, r);
      p_pr = pr;
      p_avg = m_avg;
      p_r = r;
      oe = asrc == 0 ? 0 : nc != 0 ? 1 - alm : alm;
      got.delete();
      fe.send(16'(r));
      repeat (14) @(posedge clk);
      chk(32'(got.size()), 32'(nsl));
      foreach (got[i]) begin
         x = '{1'b1, 3'(i), 3'(sq[i]), 16'(lp != 0 ? sim_d : q[sq[i]])};
         chk(32'(got[i]), 32'(x));
      end
      chk({16'h0, acode}, 32'(om == 0 ? 0 : lp != 0 ? sim_a : c));
      chk({30'h0, ven, cen}, 32'(om == 1 ? 2 : om == 2 ? 1 : 0));
      chk({30'h0, al_o, al_oe}, 32'(oe));
   endtask : smp
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      end_of_test();
   end
   initial begin
      void'($urandom(32'h6d22bcf1));
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      gain = 1024;
      ovr = -1;
      nsl = 1;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      apb(1'b0, `TSP_A_CTRL, 32'h0, rd, e);
      chk(rd, `TSP_RST_CTRL);
      apb(1'b0, `TSP_A_CAL, 32'h0, rd, e);
      chk(rd, `TSP_RST_CAL);
      apb(1'b0, 8'h2c, 32'h0, rd, e);
      chk({rd[30:0], e}, 32'h1);
      apb(1'b1, 8'h05, 32'hffff_ffff, rd, e);
      chk({31'h0, e}, 32'h1);
      apb(1'b1, `TSP_A_STAT, 32'hffff_ffff, rd, e);
      apb(1'b0, `TSP_A_STAT, 32'h0, rd, e);
      chk(rd, 32'h0);
      ctl = $urandom_range(0, 1000);
      hd = $urandom_range(0, 1000);
      fe.levels(16'(ctl), 16'(hd));
      // Slots 0..4 carry raw, processed, head, averaged, controller
      wr(`TSP_A_SLOT, 32'h0000_3302);
      wr(`TSP_A_ALVL, {16'd1100, 16'd100});
      wr(`TSP_A_ATMP, {16'd1000, 16'd0});
      nsl = 5;
      om = 1;
      cfg();
      repeat (3) smp($urandom_range(100, 900));
      om = 2;
      lg = 1;
      cfg();
      repeat (4) smp($urandom_range(100, 900));
      hys = 1;
      avgh = 50;
      nsl = 2;
      wr(`TSP_A_AVGH, 32'd50);
      cfg();
      foreach (hv[i]) smp(hv[i]);
      hys = 0;
      lg = 0;
      nsl = 5;
      off = -7;
      cfg();
      wr(`TSP_A_CAL, {16'h0400, 16'hfff9});
      repeat (2) smp($urandom_range(100, 900));
      off = 0;
      gain = 2048;
      wr(`TSP_A_CAL, 32'h0800_0000);
      repeat (2) smp($urandom_range(100, 900));
      gain = 1024;
      wr(`TSP_A_CAL, `TSP_RST_CAL);
      hm = 2;
      wr(`TSP_A_HTIM, {16'd2, 16'd2});
      cfg();
      smp(950);
      ovr = 950;
      smp(300);
      smp(300);
      ovr = -1;
      smp(300);
      hm = 1;
      cfg();
      ovr = -1;
      smp(50);
      ovr = 50;
      smp(700);
      hm = 4;
      wr(`TSP_A_HTHR, 32'd500);
      cfg();
      ovr = -1;
      smp(990);
      ovr = 990;
      smp(700);
      ovr = -1;
      hm = 3;
      cfg();
      smp(200);
      ovr = 200;
      smp(300);
      smp(600);
      ovr = -1;
      smp(400);
      hh = 1;
      wr(`TSP_A_HTHR, {16'd150, 16'd500});
      cfg();
      ovr = 400;
      smp(700);
      smp(450);
      ovr = -1;
      smp(600);
      hm = 4;
      cfg();
      smp(800);
      ovr = 800;
      smp(400);
      smp(700);
      ovr = -1;
      smp(600);
      ovr = -1;
      hm = 0;
      cfg();
      smp(640);
      lp = 1;
      sim_d = $urandom_range(0, 65535);
      sim_a = $urandom_range(0, 65535);
      wr(`TSP_A_SIM, {16'(sim_a), 16'(sim_d)});
      cfg();
      smp(500);
      lp = 0;
      om = 0;
      cfg();
      smp(500);
      om = 1;
      asrc = 3;
      athr = 500;
      ah = 100;
      wr(`TSP_A_ALRM, {16'd100, 16'd500});
      cfg();
      smp(100);
      smp(600);
      smp(450);
      adv = 1;
      cfg();
      smp(600);
      smp(450);
      smp(350);
      nc = 1;
      cfg();
      smp(600);
      smp(350);
      for (int k = 1; k < 7; k++) begin
         asrc = k;
         cfg();
         smp($urandom_range(0, 1000));
      end
      asrc = 0;
      cfg();
      smp(600);
      end_of_test();
   end
endmodule : tsp_top_tb
`default_nettype wire
